/* File: pkg/ats_pkg.sv */
// Package: register map, field layout, trigger codes and carrier types of the sample sequencer
package ats_pkg;

	// APB, result buffer, channel and counter geometry
	localparam int AW    = 8;
	localparam int DW    = 32;
	localparam int RES_W = 10;
	localparam int BUF_N = 16;
	localparam int PTR_W = 4;
	localparam int CH_N  = 4;
	localparam int CNT_W = 6;

	// Conversion length in converter clock periods
	localparam int CONV_TAD_DEF = 12;

	// Register byte offsets and result region code
	localparam logic [AW-1:0] OFF_CTRL     = 8'h00;
	localparam logic [AW-1:0] OFF_TIMING   = 8'h04;
	localparam logic [AW-1:0] OFF_CMD      = 8'h08;
	localparam logic [AW-1:0] OFF_STATUS   = 8'h0C;
	localparam logic [AW-1:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [AW-1:0] OFF_IRQ_MASK = 8'h14;
	localparam logic [1:0]    RES_REGION   = 2'h1;

	// CTRL fields
	localparam int CTRL_EN       = 0;
	localparam int CTRL_AUTO_SAMPLE_ENABLE     = 1;
	localparam int CTRL_SIM      = 2;
	localparam int CTRL_EXT_FALL = 3;
	localparam int CTRL_TRIG_LSB = 4;
	localparam int CTRL_CHANNELS_PER_SAMPLE_LSB = 8;

	// TIMING fields
	localparam int TIM_AUTO_SAMPLE_TIME_LSB = 0;
	localparam int TIM_DIV_LSB  = 8;

	// CMD bits (write only, read zero)
	localparam int CMD_SAMPLE  = 0;
	localparam int CMD_CONVERT = 1;
	localparam int CMD_PTR_CLR = 2;

	// STATUS fields
	localparam int ST_DONE    = 0;
	localparam int ST_SAMP    = 1;
	localparam int ST_PTR_LSB = 4;

	// Interrupt status / mask bits
	localparam int IRQ_W    = 3;
	localparam int IRQ_SEQ  = 0;
	localparam int IRQ_RES  = 1;
	localparam int IRQ_MISS = 2;

	// Conversion trigger select codes
	localparam logic [2:0] TRIG_MANUAL  = 3'h0;
	localparam logic [2:0] TRIG_EXT     = 3'h1;
	localparam logic [2:0] TRIG_TIMER   = 3'h2;
	localparam logic [2:0] TRIG_PWM     = 3'h3;
	localparam logic [2:0] TRIG_CLOCKED = 3'h7;

	// Reset values
	localparam logic [4:0]       AUTO_SAMPLE_TIME_RST = 5'h01;
	localparam logic [CNT_W-1:0] DIV_RST  = 6'h01;

	typedef enum logic [1:0] {ATS_IDLE, ATS_SAMPLE, ATS_CONVERT} ats_state_t;

	typedef struct packed {
		logic          psel;
		logic          penable;
		logic          pwrite;
		logic [AW-1:0] paddr;
		logic [DW-1:0] pwdata;
	} ats_apb_req_t;

	typedef struct packed {
		logic          pready;
		logic          pslverr;
		logic [DW-1:0] prdata;
	} ats_apb_rsp_t;

	// Sample-and-hold channel control
	typedef struct packed {
		logic [CH_N-1:0] sample;
		logic            convert;
		logic [1:0]      chan;
	} ats_sh_t;

	// Trigger sources
	typedef struct packed {
		logic          ext_pin;
		logic          pwm_event;
		logic [31:0]   timer_count;
		logic [31:0]   timer_period;
	} ats_trig_t;

endpackage : ats_pkg

/* File: design/ats_seq.sv */
// Design: trigger-driven sample/convert sequencer with APB registers and result buffer
`timescale 1ns/1ps

// Behaviour
// - Sequential multi-channel mode samples right before each channel's own conversion.
// - Clocked trigger ends sampling after auto_sample_time converter clock periods.
// - Simultaneous or single channel: sample time is auto_sample_time times TAD.
// - Clocked sequential: sequence lasts channels times (sample time plus conversion).
// - Sequential: a channel samples for the whole sequence except its own conversion.
// - Channels per sample come from the two-bit channels_per_sample field.
// - Select 001: active edge on external_interrupt_pin ends sampling, starts conversion.
// - External pin trigger edge selectable as rising or falling.
// - Select 010: cascaded timer pair matching combined period makes the trigger.
// - Only the cascaded timer pair may trigger; the second pair never does.
// - Select 011: PWM special event ends sampling and starts conversion.
// - Event modes with auto sampling restart sampling after each sequence.
// - Timer trigger with auto sampling converts at the timer match rate.
// - Simultaneous event mode: all channels sample on enable or after last conversion.
// - In event modes the trigger stops sampling and starts conversions.
// - Sequential event mode: channel stops sampling for its conversion, then resumes.
// - Status shows sampling and done; done sets at sequence end and holds, also in idle, until a one is written to it.
module ats_seq #(
	parameter int CONV_TAD = ats_pkg::CONV_TAD_DEF
) (
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	input  wire ats_pkg::ats_apb_req_t      apb_req,
	output ats_pkg::ats_apb_rsp_t           apb_rsp,
	input  wire ats_pkg::ats_trig_t         trig_in,
	input  wire logic [ats_pkg::RES_W-1:0]  adc_result,
	output ats_pkg::ats_sh_t                sh_out,
	output logic                            irq
);
	import ats_pkg::*;

	localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_TAD - 1);

	// Result window: region code in the top address bits, word index above the byte bits
	localparam int RES_REG_LSB = 6;
	localparam int RES_IDX_LSB = 2;
	localparam int BYTE_W      = 2;

	typedef struct packed {
		ats_state_t                   st;
		logic                         en;
		logic                         auto_sample_enable;
		logic                         sim;
		logic                         ext_fall;
		logic [2:0]                   trig;
		logic [1:0]                   channels_per_sample;
		logic [4:0]                   auto_sample_time;
		logic [CNT_W-1:0]             tad_div;
		logic [CNT_W-1:0]             tad_cnt;
		logic [CNT_W-1:0]             phase;
		logic [1:0]                   ch;
		logic                         done;
		logic [PTR_W-1:0]             ptr;
		logic [BUF_N-1:0][RES_W-1:0]  buffer;
		logic [IRQ_W-1:0]             irq_stat;
		logic [IRQ_W-1:0]             irq_mask;
		logic                         ext_d;
		logic                         match_d;
		ats_sh_t                      sh;
		logic                         irq;
		ats_apb_rsp_t                 rsp;
	} ats_regs_t;

	ats_regs_t r_r;
	ats_regs_t r_nxt;

	// Combinational helpers
	logic             setup;
	logic             access;
	logic             wr;
	logic [DW-1:0]    wd;
	logic             tad_tick;
	logic             pin_lvl;
	logic             ext_edge;
	logic             match;
	logic             trig_evt;
	logic             event_mode;
	logic             clocked;
	logic [1:0]       last_ch;
	logic [CH_N-1:0]  active;
	logic             seq;
	logic [CNT_W-1:0] phase_inc;
	logic             samp_end;
	logic             conv_end;
	logic             start_cmd;
	logic             conv_cmd;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic             done_clr;
	logic             res_hit;
	logic [PTR_W-1:0] res_idx;

	// Register all state in one place
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			r_r          <= '0;
			r_r.st       <= ATS_IDLE;
			r_r.auto_sample_time     <= AUTO_SAMPLE_TIME_RST;
			r_r.tad_div  <= DIV_RST;
		end
		else
		begin
			r_r <= r_nxt;
		end
	end

	// Bus phases and trigger detection
	always_comb
	begin
		setup     = apb_req.psel && !apb_req.penable;
		access    = apb_req.psel && apb_req.penable && r_r.rsp.pready;
		wr        = access && apb_req.pwrite;
		wd        = apb_req.pwdata;
		// A divider lowered below the running count still ticks at once
		tad_tick  = r_r.en && (r_r.tad_cnt >= r_r.tad_div);
		pin_lvl   = trig_in.ext_pin;
		// Edge from the raw pin history, so a polarity change alone never fires
		if (r_r.ext_fall)
		begin
			ext_edge = !pin_lvl && r_r.ext_d;
		end
		else
		begin
			ext_edge = pin_lvl && !r_r.ext_d;
		end
		// Only the cascaded pair is compared; no second pair input exists
		match     = (trig_in.timer_count == trig_in.timer_period);
		clocked   = (r_r.trig == TRIG_CLOCKED);
		event_mode = (r_r.trig == TRIG_EXT) || (r_r.trig == TRIG_TIMER) || (r_r.trig == TRIG_PWM);
		case (r_r.trig)
			TRIG_EXT:   trig_evt = ext_edge;
			TRIG_TIMER: trig_evt = match && !r_r.match_d;
			TRIG_PWM:   trig_evt = trig_in.pwm_event;
			// Manual, clocked and reserved codes raise no event
			default:    trig_evt = 1'b0;
		endcase
		// Channel count: 00 one, 01 two, 1x four
		case (r_r.channels_per_sample)
			2'h0:    last_ch = 2'h0;
			2'h1:    last_ch = 2'h1;
			default: last_ch = 2'h3;
		endcase
		seq       = !r_r.sim && (last_ch != 2'h0);
		phase_inc = r_r.phase + 6'h01;
		// A zero sample time still gives one TAD of sampling
		samp_end  = tad_tick && (phase_inc >= {1'b0, r_r.auto_sample_time});
		conv_end  = tad_tick && (r_r.phase == CONV_LAST);
		start_cmd = wr && (apb_req.paddr == OFF_CMD) && wd[CMD_SAMPLE];
		conv_cmd  = wr && (apb_req.paddr == OFF_CMD) && wd[CMD_CONVERT];
		irq_clr   = (wr && (apb_req.paddr == OFF_IRQ_STAT)) ? wd[IRQ_W-1:0] : '0;
		done_clr  = wr && (apb_req.paddr == OFF_STATUS) && wd[ST_DONE];
		// Result words are read only and must be word aligned
		res_hit   = (apb_req.paddr[RES_REG_LSB +: $bits(RES_REGION)] == RES_REGION) && (apb_req.paddr[BYTE_W-1:0] == '0);
		res_idx   = apb_req.paddr[RES_IDX_LSB +: PTR_W];
	end

	// Channel takes part when it is not above the last active one
	for (genvar gi = 0; gi < CH_N; gi++)
	begin : g_active
		assign active[gi] = (2'(gi) <= last_ch);
	end

	// Sequencer, register file and bus responses
	always_comb
	begin
		r_nxt   = r_r;
		irq_set = '0;

		// Trigger history and converter clock divider
		r_nxt.ext_d   = pin_lvl;
		r_nxt.match_d = match;
		r_nxt.tad_cnt = (tad_tick || !r_r.en) ? '0 : r_r.tad_cnt + 6'h01;

		// Done is cleared by writing one; a set in the same cycle wins below
		if (done_clr)
		begin
			r_nxt.done = 1'b0;
		end

		// A trigger that lands outside sampling is dropped and reported
		if (trig_evt && (r_r.st != ATS_SAMPLE))
		begin
			irq_set[IRQ_MISS] = 1'b1;
		end

		case (r_r.st)
			ATS_IDLE:
			begin
				// Auto sampling starts at enable, otherwise a start command
				if (r_r.en && (r_r.auto_sample_enable || start_cmd))
				begin
					r_nxt.st    = ATS_SAMPLE;
					r_nxt.phase = '0;
					r_nxt.ch    = '0;
				end
			end
			ATS_SAMPLE:
			begin
				if (tad_tick)
				begin
					r_nxt.phase = phase_inc;
				end
				// Clocked ends on the count, event on a trigger, manual on command
				if ((clocked && samp_end) || (event_mode && trig_evt) ||
				    (!clocked && !event_mode && conv_cmd))
				begin
					r_nxt.st    = ATS_CONVERT;
					r_nxt.phase = '0;
				end
			end
			ATS_CONVERT:
			begin
				if (tad_tick)
				begin
					r_nxt.phase = phase_inc;
				end
				if (conv_end)
				begin
					// Result taken on the last tick; the pointer wraps after the last word
					r_nxt.buffer[r_r.ptr] = adc_result;
					r_nxt.ptr             = r_r.ptr + 4'h1;
					irq_set[IRQ_RES]      = 1'b1;
					r_nxt.phase           = '0;
					if (r_r.ch == last_ch)
					begin
						r_nxt.done       = 1'b1;
						irq_set[IRQ_SEQ] = 1'b1;
						r_nxt.ch         = '0;
						// Auto sampling rearms; clearing it lets the sequence finish
						r_nxt.st = r_r.auto_sample_enable ? ATS_SAMPLE : ATS_IDLE;
					end
					else
					begin
						r_nxt.ch = r_r.ch + 2'h1;
						// Clocked sequential puts a sample slot before each channel
						r_nxt.st = (seq && clocked) ? ATS_SAMPLE : ATS_CONVERT;
					end
				end
			end
			default:
			begin
				r_nxt.st = ATS_IDLE;
			end
		endcase

		// Disabling aborts at once; a half-done conversion is not stored
		if (!r_r.en)
		begin
			r_nxt.st    = ATS_IDLE;
			r_nxt.phase = '0;
			r_nxt.ch    = '0;
		end

		// Register writes take effect at the access edge
		// Status and interrupt status clear through their own strobes above
		if (wr)
		begin
			if (apb_req.paddr == OFF_CTRL)
			begin
				r_nxt.en       = wd[CTRL_EN];
				r_nxt.auto_sample_enable     = wd[CTRL_AUTO_SAMPLE_ENABLE];
				r_nxt.sim      = wd[CTRL_SIM];
				r_nxt.ext_fall = wd[CTRL_EXT_FALL];
				r_nxt.trig     = wd[CTRL_TRIG_LSB +: 3];
				r_nxt.channels_per_sample     = wd[CTRL_CHANNELS_PER_SAMPLE_LSB +: 2];
			end
			else if (apb_req.paddr == OFF_TIMING)
			begin
				r_nxt.auto_sample_time    = wd[TIM_AUTO_SAMPLE_TIME_LSB +: 5];
				r_nxt.tad_div = wd[TIM_DIV_LSB +: CNT_W];
			end
			else if (apb_req.paddr == OFF_CMD)
			begin
				if (wd[CMD_PTR_CLR])
				begin
					r_nxt.ptr = '0;
				end
			end
			else if (apb_req.paddr == OFF_IRQ_MASK)
			begin
				r_nxt.irq_mask = wd[IRQ_W-1:0];
			end
		end

		// Sticky interrupt flags, set beats clear
		// Level output built from the next flags so it rises with them
		r_nxt.irq_stat = (r_r.irq_stat & ~irq_clr) | irq_set;
		r_nxt.irq      = |(r_nxt.irq_stat & r_nxt.irq_mask);

		// Channel controls follow the next state
		// Registered from the next state so they agree with the status bits
		r_nxt.sh.convert = (r_nxt.st == ATS_CONVERT);
		r_nxt.sh.chan    = r_nxt.ch;
		case (r_nxt.st)
			ATS_SAMPLE:
			begin
				r_nxt.sh.sample = active;
			end
			ATS_CONVERT:
			begin
				// Sequential: of the active channels only the converting one holds
				r_nxt.sh.sample = seq ? (active & ~(CH_N'(1) << r_nxt.ch)) : '0;
			end
			default:
			begin
				r_nxt.sh.sample = '0;
			end
		endcase

		// Read data and decode in the setup cycle, ready one cycle later
		r_nxt.rsp.pready  = setup;
		r_nxt.rsp.pslverr = 1'b0;
		r_nxt.rsp.prdata  = '0;
		if (setup)
		begin
			if (apb_req.paddr == OFF_CTRL)
			begin
				r_nxt.rsp.prdata[CTRL_EN]            = r_r.en;
				r_nxt.rsp.prdata[CTRL_AUTO_SAMPLE_ENABLE]          = r_r.auto_sample_enable;
				r_nxt.rsp.prdata[CTRL_SIM]           = r_r.sim;
				r_nxt.rsp.prdata[CTRL_EXT_FALL]      = r_r.ext_fall;
				r_nxt.rsp.prdata[CTRL_TRIG_LSB +: 3] = r_r.trig;
				r_nxt.rsp.prdata[CTRL_CHANNELS_PER_SAMPLE_LSB +: 2] = r_r.channels_per_sample;
			end
			else if (apb_req.paddr == OFF_TIMING)
			begin
				r_nxt.rsp.prdata[TIM_AUTO_SAMPLE_TIME_LSB +: 5]    = r_r.auto_sample_time;
				r_nxt.rsp.prdata[TIM_DIV_LSB +: CNT_W] = r_r.tad_div;
			end
			else if (apb_req.paddr == OFF_CMD)
			begin
				// Command bits are strobes and read back as zero
				r_nxt.rsp.prdata = '0;
			end
			else if (apb_req.paddr == OFF_STATUS)
			begin
				r_nxt.rsp.prdata[ST_DONE]            = r_r.done;
				r_nxt.rsp.prdata[ST_SAMP]            = (r_r.st == ATS_SAMPLE);
				r_nxt.rsp.prdata[ST_PTR_LSB +: PTR_W] = r_r.ptr;
			end
			else if (apb_req.paddr == OFF_IRQ_STAT)
			begin
				r_nxt.rsp.prdata[IRQ_W-1:0] = r_r.irq_stat;
			end
			else if (apb_req.paddr == OFF_IRQ_MASK)
			begin
				r_nxt.rsp.prdata[IRQ_W-1:0] = r_r.irq_mask;
			end
			else if (res_hit)
			begin
				r_nxt.rsp.prdata[RES_W-1:0] = r_r.buffer[res_idx];
			end
			else
			begin
				// Holes in the map answer with an error; writes there are dropped
				r_nxt.rsp.pslverr = 1'b1;
			end
		end
	end

	// Outputs straight from the state flops
	assign apb_rsp = r_r.rsp;
	assign sh_out  = r_r.sh;
	assign irq     = r_r.irq;

endmodule : ats_seq

/* File: tb/ats_seq_chk.sv */
// Checker: port-level assertions of the sample sequencer
`timescale 1ns/1ps
module ats_seq_chk #(
	parameter int CONV_TAD = ats_pkg::CONV_TAD_DEF
) (
	input wire logic                     clk,
	input wire logic                     rst_b,
	input wire ats_pkg::ats_apb_req_t    apb_req,
	input wire ats_pkg::ats_apb_rsp_t    apb_rsp,
	input wire ats_pkg::ats_trig_t       trig_in,
	input wire logic [ats_pkg::RES_W-1:0] adc_result,
	input wire ats_pkg::ats_sh_t         sh_out,
	input wire logic                     irq
);
	import ats_pkg::*;
	logic [DW-1:0] ctrl_q;
	logic          tmatch;
	logic          mapped;
	logic          smp;

	// Shadow of the control word, taken at the edge where the write lands
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			ctrl_q <= '0;
		else if (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready && apb_req.paddr == OFF_CTRL)
			ctrl_q <= apb_req.pwdata;

	// Timer match, decoded space, sampling without conversion
	assign tmatch = trig_in.timer_count == trig_in.timer_period;
	assign mapped = apb_req.paddr[1:0] == 2'h0 && (apb_req.paddr <= OFF_IRQ_MASK || apb_req.paddr[7:6] == RES_REGION);
	assign smp    = ctrl_q[CTRL_EN] && sh_out.sample != '0 && !sh_out.convert;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	a_pready_after: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
		else $error("pready missing after setup");
	a_pready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("pready longer than one cycle");
	a_rdata_idle: assert property (!apb_rsp.pready |-> apb_rsp.prdata == '0)
		else $error("prdata not zero outside answer");
	a_slverr_map: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !mapped)
		else $error("pslverr does not match address map");
	a_conv_no_samp: assert property (sh_out.convert |-> !sh_out.sample[sh_out.chan])
		else $error("converting channel still sampling");
	a_ext_trig: assert property (ctrl_q[6:4] == TRIG_EXT && smp &&
		(ctrl_q[CTRL_EXT_FALL] ? $fell(trig_in.ext_pin) : $rose(trig_in.ext_pin)) |-> ##[1:2] sh_out.convert)
		else $error("pin edge did not start conversion");
	a_timer_trig: assert property (ctrl_q[6:4] == TRIG_TIMER && smp && $rose(tmatch) |-> ##[1:2] sh_out.convert)
		else $error("timer match did not start conversion");
	a_pwm_trig: assert property (ctrl_q[6:4] == TRIG_PWM && smp && trig_in.pwm_event |-> ##[1:2] sh_out.convert)
		else $error("pwm event did not start conversion");
	a_abort_idle: assert property (!ctrl_q[CTRL_EN] [*2] |-> sh_out == '0)
		else $error("sequencer active while disabled");
endmodule : ats_seq_chk

/* File: tb/ats_sh_model.sv */
// Analog side model: sample-and-hold channels and cascaded timer pair
`timescale 1ns/1ps
module ats_sh_model (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire ats_pkg::ats_sh_t     sh,
	input  wire logic [31:0]          period,
	output logic [ats_pkg::RES_W-1:0] adc_result,
	output logic [31:0]               timer_count
);
	import ats_pkg::*;

	// Result is valid only while converting; otherwise it toggles so a stray capture shows
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			adc_result <= '0;
		else if (sh.convert)
			adc_result <= {8'h54, sh.chan};
		else
			adc_result <= ~adc_result;

	// Free-running count that wraps at the combined period, so matches repeat
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			timer_count <= '0;
		else if (timer_count >= period)
			timer_count <= '0;
		else
			timer_count <= timer_count + 32'h1;
endmodule : ats_sh_model

/* File: tb/test_adc_trigger_sample_sequencer.sv */
// Testbench: register-level scenarios for the sample sequencer
`timescale 1ns/1ps
module test_adc_trigger_sample_sequencer;
	import ats_pkg::*;
	localparam int          CT  = 4;
	localparam logic [31:0] PER = 32'h1F;
	logic             clk;
	logic             rst_b;
	logic             irq;
	logic             ext;
	logic             pwm;
	logic             e;
	logic [31:0]      q;
	logic [31:0]      tcnt;
	logic [RES_W-1:0] res;
	ats_apb_req_t     req;
	ats_apb_rsp_t     rsp;
	ats_trig_t        trg;
	ats_sh_t          sh;
	int               n_fail;
	int               num_checks;
	int               g;
	int               n;

	assign trg = '{ext, pwm, tcnt, PER};

	// Short conversion keeps sequences brief
	ats_seq #(.CONV_TAD(CT)) u_dut (.clk(clk), .rst_b(rst_b), .apb_req(req), .apb_rsp(rsp),
		.trig_in(trg), .adc_result(res), .sh_out(sh), .irq(irq));
	ats_sh_model u_sh (.clk(clk), .rst_b(rst_b), .sh(sh), .period(PER), .adc_result(res), .timer_count(tcnt));

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_of_test

	// Every polling loop steps through here, so a hang ends the run
	task automatic guard(inout int k);
		@(negedge clk);
		k++;
		if (k > 3000)
		begin
			chk("timeout", 32'h0, 32'h1);
			end_of_test();
		end
	endtask : guard

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		req.penable <= 1'b1;
		// Request stands until pready is seen at a rising edge; the answer is taken there
		@(posedge clk);
		while (rsp.pready !== 1'b1)
		begin
			guard(k);
			@(posedge clk);
		end
		q = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
	endtask : apb

	// Cycles from start of channel 0 conversion to start of channel 1
	task automatic gap(output int c);
		int k;
		k = 0;
		c = 0;
		while (sh.convert !== 1'b0)
			guard(k);
		while (!(sh.convert === 1'b1 && sh.chan === 2'h0))
			guard(k);
		while (!(sh.convert === 1'b1 && sh.chan === 2'h1))
		begin
			guard(k);
			c++;
		end
	endtask : gap

	// Enable an event mode, fire the pin or PWM event while sampling; a timer match comes on its own
	task automatic ev(input logic [2:0] code, input logic fall);
		int k;
		k = 0;
		@(posedge clk);
		ext <= fall;
		apb(1'b1, OFF_CTRL, 32'({code, fall, 3'h3}));
		while (sh.sample === 4'h0)
			guard(k);
		@(posedge clk);
		if (code == TRIG_EXT)
			ext <= ~fall;
		pwm <= code == TRIG_PWM;
		@(posedge clk);
		pwm <= 1'b0;
		k = 0;
		while (sh.convert !== 1'b1)
			guard(k);
		chk("trigger latency", 32'h1, 32'(k <= (code == TRIG_TIMER ? 40 : 2)));
	endtask : ev

	initial
	begin
		req = '0;
		ext = 1'b0;
		pwm = 1'b0;
		rst_b = 1'b0;
		n_fail = 0;
		num_checks = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, q);
		apb(1'b0, OFF_TIMING, 32'h0);
		chk("timing reset", 32'h101, q);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped error", 32'h1, 32'(e));
		apb(1'b1, OFF_TIMING, 32'h3);
		apb(1'b1, OFF_IRQ_MASK, 32'h1);
		// One channel, clocked end of sampling
		apb(1'b1, OFF_CTRL, 32'h73);
		n = 0;
		g = 0;
		while (sh.convert !== 1'b1)
		begin
			guard(n);
			if (sh.sample !== 4'h0)
				g++;
		end
		chk("sample length", 32'h3, 32'(g));
		while (irq !== 1'b1)
			guard(n);
		apb(1'b1, OFF_IRQ_MASK, 32'h0);
		repeat (2) @(negedge clk);
		chk("masked irq", 32'h0, 32'(irq));
		apb(1'b1, OFF_CTRL, 32'h0);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("done status", 32'h1, 32'(q[1:0]));
		apb(1'b0, 8'h40, 32'h0);
		chk("first result", 32'h150, q);
		apb(1'b1, OFF_STATUS, 32'h1);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("idle status", 32'h0, 32'(q[1:0]));
		apb(1'b1, OFF_IRQ_STAT, 32'h7);
		apb(1'b0, OFF_IRQ_STAT, 32'h0);
		chk("irq cleared", 32'h0, q);
		// Four channels sampled together, results in order
		apb(1'b1, OFF_IRQ_MASK, 32'h1);
		apb(1'b1, OFF_CMD, 32'h4);
		apb(1'b1, OFF_CTRL, 32'h277);
		gap(g);
		chk("simultaneous gap", 32'(CT), 32'(g));
		while (irq !== 1'b1)
			guard(n);
		apb(1'b1, OFF_CTRL, 32'h0);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("pointer", 32'h4, 32'(q[7:4]));
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, 8'(8'h40 + 4 * i), 32'h0);
			chk("result word", 32'h150 + 32'(i), q);
		end
		// Two channels sequential, own sample slot before each conversion
		apb(1'b1, OFF_CTRL, 32'h173);
		gap(g);
		chk("sequential gap", 32'(CT + 3), 32'(g));
		ev(TRIG_EXT, 1'b0);
		ev(TRIG_EXT, 1'b1);
		ev(TRIG_TIMER, 1'b0);
		n = 0;
		g = 0;
		while (sh.convert !== 1'b0)
		begin
			guard(n);
			g++;
		end
		while (sh.convert !== 1'b1)
		begin
			guard(n);
			g++;
		end
		chk("timer rate", PER + 32'h1, 32'(g));
		apb(1'b1, OFF_CTRL, 32'h0);
		apb(1'b1, OFF_IRQ_STAT, 32'h7);
		ev(TRIG_PWM, 1'b0);
		@(posedge clk);
		pwm <= 1'b1;
		@(posedge clk);
		pwm <= 1'b0;
		apb(1'b0, OFF_IRQ_STAT, 32'h0);
		chk("missed trigger", 32'h1, 32'(q[IRQ_MISS]));
		// Manual mode: start and convert by command, status follows
		apb(1'b1, OFF_CTRL, 32'h0);
		apb(1'b1, OFF_STATUS, 32'h1);
		apb(1'b1, OFF_CTRL, 32'h1);
		apb(1'b1, OFF_CMD, 32'h1);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("sampling status", 32'h2, 32'(q[1:0]));
		apb(1'b1, OFF_CMD, 32'h2);
		repeat (2 * CT) @(negedge clk);
		apb(1'b0, OFF_STATUS, 32'h0);
		chk("manual done", 32'h1, 32'(q[1:0]));
		end_of_test();
	end
endmodule : test_adc_trigger_sample_sequencer

bind ats_seq ats_seq_chk #(.CONV_TAD(CONV_TAD)) u_chk (.clk(clk), .rst_b(rst_b), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .trig_in(trig_in), .adc_result(adc_result), .sh_out(sh_out), .irq(irq));
